/* hdl/odc_output_divider_config_regs.v */
/*
  Register bank for two output clock channels: channel a integer divider and
  20-bit fraction word, channel b control. Decoded settings drive the clock
  path as registered outputs, each straight from a flip-flop.
  Reserved bit positions are dropped on write and always read back as zero.
  A reserved prescale code is flagged rather than silently replaced when the fractional divider is enabled.

  Assumes the serial port logic delivers one-cycle write and read strobes
  with a register index and 16-bit data, all on sys_clk, so no input needs
  a synchroniser. Read data comes back through a registered port one cycle
  after the read strobe, with a one-cycle valid pulse.
  Assumes the host keeps reserved bits zero and sets the negative side
  enable only together with the positive side enable.
  Assumes rst_n is asynchronous and active low; every register clears except divide ratio, prescale ratio and LVDS select, which reset to one.
  The clock path samples the decoded settings on sys_clk as well.
*/
`include "odc_defines.vh"

module odc_output_divider_config_regs (
  input wire sys_clk,
  input wire rst_n,
  input wire cfg_wr_stb,
  input wire cfg_rd_stb,
  input wire [`ODC_ADDR_W-1:0] cfg_addr,
  input wire [`ODC_DATA_W-1:0] cfg_wdata,
  output reg [`ODC_DATA_W-1:0] cfg_rdata_ff,
  output reg cfg_rd_valid_ff,
  output reg cfg_addr_err_ff,
  output reg [8:0] chan_a_divide_ratio_ff,
  output reg [19:0] chan_a_fraction_word_ff,
  output reg [1:0] chan_b_prescale_ratio_ff,
  output reg chan_b_prescale_bad_ff,
  output reg chan_b_fraction_enable_ff,
  output reg chan_b_single_ended_slew_ff,
  output reg chan_b_positive_side_enable_ff,
  output reg chan_b_negative_side_enable_ff,
  output reg chan_b_lvds_sel_ff,
  output reg chan_b_lvcmos_sel_ff,
  output reg chan_b_hcsl_sel_ff,
  output reg chan_b_clock_run_ff,
  output reg chan_b_static_drive_ff,
  output reg chan_b_static_level_ff,
  output reg chan_b_supply_select_ff
);

  reg [`ODC_DATA_W-1:0] int_frac_hi_ff;
  reg [`ODC_DATA_W-1:0] frac_lo_ff;
  reg [`ODC_DATA_W-1:0] chb_ctrl_ff;
  reg [`ODC_DATA_W-1:0] nxt_rdata;
  reg nxt_addr_err;
  wire [7:0] chan_a_integer_divider;
  wire [2:0] chan_b_prescale_select;
  wire chan_b_fraction_enable_bit;
  wire [1:0] chan_b_driver_type;
  wire [1:0] chan_b_output_mode;

  // Index decode, shared by write and read paths
  function is_mapped;
    input [`ODC_ADDR_W-1:0] idx;
    begin
      is_mapped = (idx == `ODC_IDX_INT_FRAC_HI) || (idx == `ODC_IDX_FRAC_LO) ||
                  (idx == `ODC_IDX_CHB_CTRL);
    end
  endfunction

  // Prescale code to ratio; zero marks a reserved code
  function [1:0] prescale_ratio;
    input [2:0] code;
    begin
      case (code)
        `ODC_PRE_DIV2: prescale_ratio = `ODC_RATIO_2;
        `ODC_PRE_DIV3: prescale_ratio = `ODC_RATIO_3;
        `ODC_PRE_DIV1: prescale_ratio = `ODC_RATIO_1;
        default: prescale_ratio = `ODC_RATIO_BAD;
      endcase
    end
  endfunction

  // Field views of the stored registers
  assign chan_a_integer_divider = int_frac_hi_ff[`ODC_INTDIV_HI:`ODC_INTDIV_LO];
  assign chan_b_prescale_select = chb_ctrl_ff[`ODC_PRE_HI:`ODC_PRE_LO];
  assign chan_b_fraction_enable_bit = chb_ctrl_ff[`ODC_FRACEN_BIT];
  assign chan_b_driver_type = chb_ctrl_ff[`ODC_DRV_HI:`ODC_DRV_LO];
  assign chan_b_output_mode = chb_ctrl_ff[`ODC_MODE_HI:`ODC_MODE_LO];

  // Register storage; reserved bits are masked so they always read zero
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_frac_hi_ff <= `ODC_RST_VAL;
      frac_lo_ff <= `ODC_RST_VAL;
      chb_ctrl_ff <= `ODC_RST_VAL;
    end
    else if (cfg_wr_stb)
    begin
      case (cfg_addr)
        `ODC_IDX_INT_FRAC_HI: int_frac_hi_ff <= cfg_wdata & `ODC_INT_FRAC_HI_MASK;
        `ODC_IDX_FRAC_LO: frac_lo_ff <= cfg_wdata & `ODC_FRAC_LO_MASK;
        `ODC_IDX_CHB_CTRL: chb_ctrl_ff <= cfg_wdata & `ODC_CHB_CTRL_MASK;
        default: chb_ctrl_ff <= chb_ctrl_ff;
      endcase
    end
  end

  // Read mux
  always @*
  begin
    nxt_rdata = `ODC_RST_VAL;
    nxt_addr_err = !is_mapped(cfg_addr);
    case (cfg_addr)
      `ODC_IDX_INT_FRAC_HI: nxt_rdata = int_frac_hi_ff;
      `ODC_IDX_FRAC_LO: nxt_rdata = frac_lo_ff;
      `ODC_IDX_CHB_CTRL: nxt_rdata = chb_ctrl_ff;
      default: nxt_rdata = `ODC_RST_VAL;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_rdata_ff <= `ODC_RST_VAL;
      cfg_rd_valid_ff <= 1'b0;
      cfg_addr_err_ff <= 1'b0;
    end
    else
    begin
      cfg_rd_valid_ff <= cfg_rd_stb;
      cfg_addr_err_ff <= (cfg_rd_stb | cfg_wr_stb) & nxt_addr_err;
      if (cfg_rd_stb)
        cfg_rdata_ff <= nxt_rdata;
    end
  end

  // Next values of the decoded settings, worked out from the stored registers
  // one cycle before they reach the output flip-flops
  reg [8:0] nxt_divide_ratio;
  reg [19:0] nxt_fraction_word;
  reg [1:0] nxt_prescale_ratio;
  reg nxt_prescale_bad;
  reg [2:0] nxt_driver_onehot;
  reg nxt_clock_run;
  reg nxt_static_drive;
  reg nxt_static_level;
  reg nxt_negative_side;

  // Driver type to one-hot {lvds, lvcmos, hcsl}; both low codes mean LVDS
  function [2:0] driver_onehot;
    input [1:0] code;
    begin
      case (code)
        `ODC_DRV_LVCMOS: driver_onehot = `ODC_ONEHOT_LVCMOS;
        `ODC_DRV_HCSL: driver_onehot = `ODC_ONEHOT_HCSL;
        default: driver_onehot = `ODC_ONEHOT_LVDS;
      endcase
    end
  endfunction

  // Channel a ratio and fraction word; the ratio is one bit wider than the
  // field so that the largest code plus one still fits
  always @*
  begin
    nxt_divide_ratio = {1'h0, chan_a_integer_divider} + `ODC_DIV_STEP;
    nxt_fraction_word = {int_frac_hi_ff[`ODC_FRACHI_HI:`ODC_FRACHI_LO], frac_lo_ff};
  end

  // Prescale ratio; bypass forces unity while the fractional divider is off,
  // so a reserved code left in a disabled channel raises no flag
  always @*
  begin
    nxt_prescale_ratio = `ODC_RATIO_1;
    nxt_prescale_bad = `ODC_FLAG_CLR;
    if (chan_b_fraction_enable_bit)
    begin
      nxt_prescale_ratio = prescale_ratio(chan_b_prescale_select);
      nxt_prescale_bad = (nxt_prescale_ratio == `ODC_RATIO_BAD);
    end
  end

  // Output stage selection: driver type, run or static mode, side enables
  always @*
  begin
    nxt_driver_onehot = driver_onehot(chan_b_driver_type);
    nxt_clock_run = (chan_b_output_mode == `ODC_MODE_CLOCK);
    nxt_static_drive = (chan_b_output_mode == `ODC_MODE_LOW) || (chan_b_output_mode == `ODC_MODE_HIGH);
    nxt_static_level = (chan_b_output_mode == `ODC_MODE_HIGH);
    // Negative side only follows when the positive side is on, even if the
    // host breaks its duty and sets it alone
    nxt_negative_side = chb_ctrl_ff[`ODC_NEG_BIT] & chb_ctrl_ff[`ODC_POS_BIT];
  end

  // Channel a divider settings toward the clock path; a write shows here
  // two edges after its strobe
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_a_divide_ratio_ff <= `ODC_RATIO_RST;
      chan_a_fraction_word_ff <= `ODC_FRAC_RST;
    end
    else
    begin
      chan_a_divide_ratio_ff <= nxt_divide_ratio;
      chan_a_fraction_word_ff <= nxt_fraction_word;
    end
  end

  // Channel b prescale ratio and reserved-code flag
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_b_prescale_ratio_ff <= `ODC_RATIO_1;
      chan_b_prescale_bad_ff <= `ODC_FLAG_CLR;
    end
    else
    begin
      chan_b_prescale_ratio_ff <= nxt_prescale_ratio;
      chan_b_prescale_bad_ff <= nxt_prescale_bad;
    end
  end

  // Channel b fractional enable and single-ended slew
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_b_fraction_enable_ff <= `ODC_FLAG_CLR;
      chan_b_single_ended_slew_ff <= `ODC_FLAG_CLR;
    end
    else
    begin
      chan_b_fraction_enable_ff <= chan_b_fraction_enable_bit;
      chan_b_single_ended_slew_ff <= chb_ctrl_ff[`ODC_SLEW_BIT];
    end
  end

  // Channel b single-ended side enables and supply selection; both sides
  // come up off after reset
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_b_positive_side_enable_ff <= `ODC_FLAG_CLR;
      chan_b_negative_side_enable_ff <= `ODC_FLAG_CLR;
      chan_b_supply_select_ff <= `ODC_FLAG_CLR;
    end
    else
    begin
      chan_b_positive_side_enable_ff <= chb_ctrl_ff[`ODC_POS_BIT];
      chan_b_negative_side_enable_ff <= nxt_negative_side;
      chan_b_supply_select_ff <= chb_ctrl_ff[`ODC_SUPPLY_BIT];
    end
  end

  // Channel b driver type, one-hot; reset matches a cleared field, which
  // selects LVDS
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_b_lvds_sel_ff <= `ODC_FLAG_SET;
      chan_b_lvcmos_sel_ff <= `ODC_FLAG_CLR;
      chan_b_hcsl_sel_ff <= `ODC_FLAG_CLR;
    end
    else
    begin
      {chan_b_lvds_sel_ff, chan_b_lvcmos_sel_ff, chan_b_hcsl_sel_ff} <= nxt_driver_onehot;
    end
  end

  // Channel b output mode: clock running, static drive and its level;
  // after reset the output is off
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_b_clock_run_ff <= `ODC_FLAG_CLR;
      chan_b_static_drive_ff <= `ODC_FLAG_CLR;
      chan_b_static_level_ff <= `ODC_FLAG_CLR;
    end
    else
    begin
      chan_b_clock_run_ff <= nxt_clock_run;
      chan_b_static_drive_ff <= nxt_static_drive;
      chan_b_static_level_ff <= nxt_static_level;
    end
  end

endmodule

/* inc/odc_defines.vh */
/*
  Constants for the output divider configuration register bank:
  register indices, field positions, field codes and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ODC_DEFINES_VH
`define ODC_DEFINES_VH

// Register indices on the configuration port
`define ODC_ADDR_W 5
`define ODC_DATA_W 16
`define ODC_IDX_INT_FRAC_HI 5'h0D
`define ODC_IDX_FRAC_LO 5'h0E
`define ODC_IDX_CHB_CTRL 5'h0F

// Reset value of every register
`define ODC_RST_VAL 16'h0000

// Reset values and steps of the decoded settings
`define ODC_RATIO_RST 9'h001
`define ODC_DIV_STEP 9'h001
`define ODC_FRAC_RST 20'h00000
`define ODC_FLAG_CLR 1'h0
`define ODC_FLAG_SET 1'h1

// Integer divider and upper fraction fields
`define ODC_INTDIV_HI 11
`define ODC_INTDIV_LO 4
`define ODC_FRACHI_HI 3
`define ODC_FRACHI_LO 0
`define ODC_INT_FRAC_HI_MASK 16'h0FFF
`define ODC_FRAC_LO_MASK 16'hFFFF

// Channel b control fields
`define ODC_PRE_HI 12
`define ODC_PRE_LO 10
`define ODC_FRACEN_BIT 9
`define ODC_SLEW_BIT 8
`define ODC_NEG_BIT 7
`define ODC_POS_BIT 6
`define ODC_DRV_HI 4
`define ODC_DRV_LO 3
`define ODC_MODE_HI 2
`define ODC_MODE_LO 1
`define ODC_SUPPLY_BIT 0
`define ODC_CHB_CTRL_MASK 16'h1FDF

// Prescale codes and resulting ratios
`define ODC_PRE_DIV2 3'h0
`define ODC_PRE_DIV3 3'h1
`define ODC_PRE_DIV1 3'h7
`define ODC_RATIO_1 2'h1
`define ODC_RATIO_2 2'h2
`define ODC_RATIO_3 2'h3
`define ODC_RATIO_BAD 2'h0

// Driver types
`define ODC_DRV_LVDS 2'h0
`define ODC_DRV_LVCMOS 2'h2
`define ODC_DRV_HCSL 2'h3
`define ODC_ONEHOT_LVDS 3'h4
`define ODC_ONEHOT_LVCMOS 3'h2
`define ODC_ONEHOT_HCSL 3'h1

// Output modes
`define ODC_MODE_OFF 2'h0
`define ODC_MODE_CLOCK 2'h1
`define ODC_MODE_LOW 2'h2
`define ODC_MODE_HIGH 2'h3

`endif

/* bench/odc_chk_checker.sv */
/* Assertions on the register bank ports.
   Bound to the bank; sees its ports only. */
module odc_chk (
  input wire sys_clk,
  input wire rst_n,
  input wire cfg_wr_stb,
  input wire cfg_rd_stb,
  input wire [4:0] cfg_addr,
  input wire [15:0] cfg_wdata,
  input wire cfg_rd_valid_ff,
  input wire cfg_addr_err_ff,
  input wire chan_b_prescale_bad_ff,
  input wire [8:0] chan_a_divide_ratio_ff,
  input wire [19:0] chan_a_fraction_word_ff,
  input wire [1:0] chan_b_prescale_ratio_ff,
  input wire chan_b_fraction_enable_ff,
  input wire chan_b_supply_select_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Writes to each of the three registers
  sequence s_wa; cfg_wr_stb && cfg_addr == 5'h0D; endsequence
  sequence s_wb; cfg_wr_stb && cfg_addr == 5'h0E; endsequence
  sequence s_wc; cfg_wr_stb && cfg_addr == 5'h0F; endsequence
  sequence s_unmapped; (cfg_wr_stb || cfg_rd_stb) && !(cfg_addr inside {5'h0D, 5'h0E, 5'h0F}); endsequence
  a_addr_err: assert property (s_unmapped |=> cfg_addr_err_ff) else $error("no index error");
  a_err_quiet: assert property (!(cfg_wr_stb || cfg_rd_stb) |=> !cfg_addr_err_ff) else $error("stray index error");
  a_pre_flag: assert property (chan_b_prescale_bad_ff |-> chan_b_fraction_enable_ff && chan_b_prescale_ratio_ff == 2'h0)
    else $error("bad prescale flag");
  a_rd_valid: assert property (cfg_rd_stb |=> cfg_rd_valid_ff) else $error("no read valid");
  a_rd_quiet: assert property (!cfg_rd_stb |=> !cfg_rd_valid_ff) else $error("stray read valid");
  a_div_ratio: assert property (s_wa |-> ##2 chan_a_divide_ratio_ff == $past(cfg_wdata[11:4], 2) + 9'h1)
    else $error("bad ratio");
  a_frac_high: assert property (s_wa |-> ##2 chan_a_fraction_word_ff[19:16] == $past(cfg_wdata[3:0], 2))
    else $error("bad fraction high");
  a_frac_low: assert property (s_wb |-> ##2 chan_a_fraction_word_ff[15:0] == $past(cfg_wdata, 2))
    else $error("bad fraction low");
  a_pre_bypass: assert property (!chan_b_fraction_enable_ff |-> chan_b_prescale_ratio_ff == 2'h1)
    else $error("no bypass");
  a_frac_enable: assert property (s_wc |-> ##2 chan_b_fraction_enable_ff == $past(cfg_wdata[9], 2))
    else $error("bad enable");
  a_supply_sel: assert property (s_wc |-> ##2 chan_b_supply_select_ff == $past(cfg_wdata[0], 2))
    else $error("bad supply");
endmodule
bind odc_output_divider_config_regs odc_chk odc_chk_i (.*);

/* bench/odc_host_model.sv */
/* Serial configuration host model.
   Assumes each xfer call starts between rising edges. */
module odc_host_model (
  input wire sys_clk,
  output logic cfg_wr_stb,
  output logic cfg_rd_stb,
  output logic [4:0] cfg_addr,
  output logic [15:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial {cfg_wr_stb, cfg_rd_stb, cfg_addr, cfg_wdata} = 23'h0;
  // One request over one rising edge, then strobes cleared and address and data inverted
  task xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
    if (a == 5'h0D) d = d & 16'h0FFF;
    if (a == 5'h0F) d = d & 16'h1FDF & ~{8'h00, !d[6], 7'h00};
    @(negedge sys_clk);
    {cfg_wr_stb, cfg_rd_stb, cfg_addr, cfg_wdata} = {w, !w, a, d};
    @(negedge sys_clk);
    {cfg_wr_stb, cfg_rd_stb, cfg_addr, cfg_wdata} = {2'h0, ~a, ~d};
  endtask
endmodule

/* bench/output_divider_config_regs_tb_top.sv */
/* Self-checking bench for the register bank.
   Assumes the host model and the bound checker. */
module output_divider_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n;
  wire cfg_wr_stb, cfg_rd_stb, cfg_rd_valid_ff, cfg_addr_err_ff, chan_b_prescale_bad_ff;
  wire [4:0] cfg_addr;
  wire [15:0] cfg_wdata, cfg_rdata_ff;
  wire [8:0] chan_a_divide_ratio_ff;
  wire [19:0] chan_a_fraction_word_ff;
  wire [1:0] chan_b_prescale_ratio_ff;
  wire chan_b_fraction_enable_ff, chan_b_single_ended_slew_ff, chan_b_positive_side_enable_ff;
  wire chan_b_negative_side_enable_ff, chan_b_lvds_sel_ff, chan_b_lvcmos_sel_ff, chan_b_hcsl_sel_ff;
  wire chan_b_clock_run_ff, chan_b_static_drive_ff, chan_b_static_level_ff, chan_b_supply_select_ff;
  wire [13:0] b_got = {chan_b_fraction_enable_ff, chan_b_single_ended_slew_ff, chan_b_negative_side_enable_ff,
    chan_b_positive_side_enable_ff, chan_b_lvds_sel_ff, chan_b_lvcmos_sel_ff, chan_b_hcsl_sel_ff,
    chan_b_clock_run_ff, chan_b_static_drive_ff, chan_b_static_level_ff, chan_b_supply_select_ff,
    chan_b_prescale_ratio_ff, chan_b_prescale_bad_ff};
  int n_errors = 0, checked = 0, cyc = 0;
  logic [15:0] d [3];
  logic [2:0] pre [4] = '{3'h0, 3'h1, 3'h7, 3'h5};
  odc_output_divider_config_regs odc_output_divider_config_regs_i (.*);
  odc_host_model odc_host_model_i (.*);
  // Expected channel b outputs from a control word
  function automatic logic [13:0] exp_b(input logic [15:0] v);
    logic [1:0] pr;
    logic bad;
    bad = v[9] && !(v[12:10] inside {3'h0, 3'h1, 3'h7});
    pr = !v[9] ? 2'h1 : v[12:10] == 3'h0 ? 2'h2 : v[12:10] == 3'h1 ? 2'h3 : bad ? 2'h0 : 2'h1;
    return {v[9:6], v[4:3] < 2'h2, v[4:3] == 2'h2, v[4:3] == 2'h3,
      v[2:1] == 2'h1, v[2], v[2:1] == 2'h3, v[0], pr, bad};
  endfunction
  // Compare and count
  task chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts and verdict
  task stop_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Clock
  initial
  begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      stop_test();
    end
  end
  // Reset, random register traffic, unmapped index
  initial
  begin
    rst_n = 0;
    void'($urandom(32'hCCD8));
    repeat (2) @(negedge sys_clk);
    rst_n = 1;
    chk(20'({chan_a_divide_ratio_ff, chan_b_prescale_ratio_ff, chan_b_lvds_sel_ff}), 20'h0000B);
    $display("reset test done");
    for (int i = 0; i < 32; i++)
    begin
      foreach (d[k]) d[k] = (i == 0) ? 16'hFFFF : 16'($urandom);
      d[0][15:12] = 4'h0;
      d[2] = {3'h0, pre[i % 4], d[2][9:7] & {2'h3, d[2][6]}, d[2][6], 1'b0, 4'(i), d[2][0]};
      if (i < 4) d[2][9] = 1'b1;
      foreach (d[k]) odc_host_model_i.xfer(1'b1, 5'h0D + 5'(k), d[k]);
      foreach (d[k])
      begin
        odc_host_model_i.xfer(1'b0, 5'h0D + 5'(k), 16'h0000);
        chk(20'({cfg_rd_valid_ff, cfg_rdata_ff}), 20'({1'b1, d[k]}));
      end
      chk(20'(chan_a_divide_ratio_ff), 20'(d[0][11:4]) + 20'h1);
      chk(chan_a_fraction_word_ff, {d[0][3:0], d[1]});
      chk(20'(b_got), 20'(exp_b(d[2])));
    end
    $display("random test done");
    @(negedge sys_clk);
    rst_n = 0;
    @(negedge sys_clk);
    rst_n = 1;
    chk(20'({chan_a_divide_ratio_ff, chan_b_prescale_ratio_ff, chan_b_lvds_sel_ff}), 20'h0000B);
    odc_host_model_i.xfer(1'b0, 5'h0F, 16'h0000);
    chk(20'({cfg_rd_valid_ff, cfg_rdata_ff}), 20'h10000);
    $display("mid-run reset test done");
    odc_host_model_i.xfer(1'b0, 5'h10, 16'h0000);
    chk(20'({cfg_rd_valid_ff, cfg_addr_err_ff, cfg_rdata_ff}), 20'h30000);
    $display("unmapped test done");
    stop_test();
  end
endmodule
